// ### low_power_mode_controller.sv
// Clock dividers, module stop and low-power mode sequencing.
// What this block does
// - Separate divider ratio per internal clock.
// - Bus clock pin outputs clock or high.
// - Per-module stop bits halt single modules.
// - Low-power states halt core, peripherals, oscillators.
// - Four states: sleep, allstop, standby, deep.
// - Enter only on control setting plus wait.
// - Interrupt ends state, resumes via interrupt.
// - Sleep halts core, RAM stays accessible.
// - Sleep stops and holds window watchdog.
// - Sleep lets enabled independent watchdog run.
// - Sleep keeps port output shutoff working.
// - Sleep keeps both eight-bit timer units counting.
// - Sleep keeps USB host/function module running.
// - Allstop halts core, RAM, flash; oscillators run.
`timescale 1ns/10ps
module low_power_mode_controller
  import lpm_pkg::*;
#(
  parameter int NUM_MODULES = 32
)
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic [ADDR_W-1:0]      regAddr,
  input  wire logic [DATA_W-1:0]      regWdata,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic      [DATA_W-1:0]      regRdata,
  input  wire logic                   waitInstr,
  input  wire logic                   irqPending,
  input  wire logic                   indepWdEnabled,
  output logic      [NUM_CLK-1:0]     clkEnable,
  output logic                        busClkPin,
  output logic      [NUM_MODULES-1:0] moduleStop,
  output unit_ctl_t                   unitCtl,
  output logic                        wakeToIrq
);

  if (NUM_MODULES < 1 || NUM_MODULES > DATA_W)
  begin : g_bad_modules
    $error("NUM_MODULES must lie between 1 and 32.");
  end

  logic [31:0]            clkDiv;
  logic [NUM_MODULES-1:0] modStopReg;
  logic [2:0]             lpCtl;
  lp_mode_t               mode;
  lp_mode_t               next_mode;
  logic [DIV_CNT_W-1:0]   divCnt;
  logic                   busPhase;

  // Register decode.
  // Unmapped addresses select nothing: writes drop, reads give zero.
  wire selClkDiv = (regAddr == REG_CLKDIV);
  wire selMstop  = (regAddr == REG_MSTOP);
  wire selLpCtl  = (regAddr == REG_LPCTL);
  wire selStat   = (regAddr == REG_STAT);

  wire wrClkDiv = regWr && selClkDiv;
  wire wrMstop  = regWr && selMstop;
  wire wrLpCtl  = regWr && selLpCtl;

  wire [DATA_W-1:0] mstopWide = DATA_W'(modStopReg);

  // Status: mode in the low bits, then the two live inputs.
  wire [DATA_W-1:0] statWord = {
      26'h0,
      indepWdEnabled,
      irqPending,
      1'b0,
      mode
  };

  // Read data stand only in the cycle after the strobe.
  wire [DATA_W-1:0] next_rdata =
      !regRd    ? 32'h0000_0000 :
      selClkDiv ? clkDiv :
      selMstop  ? mstopWide :
      selLpCtl  ? {29'h0, lpCtl} :
      selStat   ? statWord : 32'h0000_0000;

  // Prohibited ratio codes are clamped to the slowest legal ratio.
  // This keeps the counter mask within its six bits.
  function automatic logic [DIV_CNT_W-1:0] ratioMask
    (input logic [SEL_W-1:0] sel);
    logic [SEL_W-1:0] s;
    s = (sel > SEL_MAX) ? SEL_MAX : sel;
    ratioMask = DIV_CNT_W'((7'h01 << s) - 7'h01);
  endfunction : ratioMask

  // One enable pulse every 2**sel core clocks per derived clock.
  // All ticks share one counter, so a slow tick always meets a fast one.
  logic [NUM_CLK-1:0] divTick;
  for (genvar i = 0; i < NUM_CLK; i++)
  begin : g_div
    wire [DIV_CNT_W-1:0] m = ratioMask(clkDiv[i*SEL_W +: SEL_W]);
    assign divTick[i] = ((divCnt & m) == m);
  end

  // Mode selection at the wait instruction.
  wire wantDeep    = lpCtl[LP_STANDBY_BIT] && lpCtl[LP_DEEP_BIT];
  wire wantStandby = lpCtl[LP_STANDBY_BIT];
  wire wantAllStop = lpCtl[LP_ALLSTOP_BIT];

  wire inLowPower = (mode != MODE_RUN);

  // A wait with an interrupt already pending still enters the state; the
  // pending interrupt then ends it at the next edge.
  always_comb
  begin
    next_mode = mode;
    case (mode)
      MODE_RUN:
      begin
        if (waitInstr)
        begin
          if (wantDeep)
            next_mode = MODE_DEEPSTBY;
          else if (wantStandby)
            next_mode = MODE_SWSTBY;
          else if (wantAllStop)
            next_mode = MODE_ALLSTOP;
          else
            next_mode = MODE_SLEEP;
        end
      end
      MODE_SLEEP, MODE_ALLSTOP, MODE_SWSTBY, MODE_DEEPSTBY:
      begin
        if (irqPending)
          next_mode = MODE_RUN;
      end
      default:
        next_mode = MODE_RUN;
    endcase
  end

  // Unit states for each mode.
  unit_ctl_t next_unit;
  always_comb
  begin
    next_unit = '0;
    next_unit.indepWdRun = indepWdEnabled;
    next_unit.shutoffRun = 1'b1;
    next_unit.timerRun   = 1'b1;
    next_unit.usbRun     = 1'b1;
    case (next_mode)
      MODE_RUN:
      begin
        next_unit.cpuHalt = 1'b0;
      end
      MODE_SLEEP:
      begin
        next_unit.cpuHalt      = 1'b1;
        next_unit.ramStop      = 1'b0;
        next_unit.flashStop    = 1'b0;
        next_unit.periphStop   = 1'b0;
        next_unit.oscStop      = 1'b0;
        next_unit.watchdogStop = 1'b1;
        next_unit.indepWdRun   = indepWdEnabled;
        next_unit.shutoffRun   = 1'b1;
        next_unit.timerRun     = 1'b1;
        next_unit.usbRun       = 1'b1;
      end
      MODE_ALLSTOP:
      begin
        next_unit.cpuHalt      = 1'b1;
        next_unit.ramStop      = 1'b1;
        next_unit.flashStop    = 1'b1;
        next_unit.periphStop   = 1'b1;
        next_unit.watchdogStop = 1'b1;
        next_unit.indepWdRun   = indepWdEnabled;
        next_unit.shutoffRun   = 1'b1;
        next_unit.timerRun     = 1'b1;
        next_unit.usbRun       = 1'b0;
        next_unit.oscStop      = 1'b0;
      end
      MODE_SWSTBY, MODE_DEEPSTBY:
      begin
        next_unit.cpuHalt      = 1'b1;
        next_unit.ramStop      = 1'b1;
        next_unit.flashStop    = 1'b1;
        next_unit.periphStop   = 1'b1;
        next_unit.watchdogStop = 1'b1;
        next_unit.shutoffRun   = 1'b0;
        next_unit.timerRun     = 1'b0;
        next_unit.usbRun       = 1'b0;
        next_unit.indepWdRun   = indepWdEnabled;
        next_unit.oscStop      = 1'b1;
        next_unit.deepPowerOff = (next_mode == MODE_DEEPSTBY);
      end
      default:
      begin
        next_unit.cpuHalt = 1'b0;
      end
    endcase
  end

  // Which derived clocks may tick in the coming mode.
  // Gating on the coming mode keeps the first tick after entry away.
  logic [NUM_CLK-1:0] clkAllowed;
  always_comb
  begin
    clkAllowed = '1;
    if (next_unit.cpuHalt)
      clkAllowed[CLK_CORE] = 1'b0;
    if (next_unit.periphStop)
    begin
      clkAllowed[CLK_PA] = 1'b0;
      clkAllowed[CLK_PB] = 1'b0;
      clkAllowed[CLK_PC] = 1'b0;
      clkAllowed[CLK_PD] = 1'b0;
      clkAllowed[CLK_BUS] = 1'b0;
    end
    if (next_unit.flashStop)
      clkAllowed[CLK_FLASH] = 1'b0;
  end

  wire [NUM_CLK-1:0] next_clkEnable = divTick & clkAllowed;

  wire busHigh = clkDiv[BCLK_HIGH_BIT];
  wire next_busPhase = divTick[CLK_BUS] && clkAllowed[CLK_BUS]
                       ? !busPhase : busPhase;
  wire next_busPin = busHigh ? 1'b1 : next_busPhase;

  wire [NUM_MODULES-1:0] next_modStop =
      modStopReg | {NUM_MODULES{next_unit.periphStop}};

  // One cycle only, so each low-power episode resumes exactly once.
  wire next_wake = inLowPower && (next_mode == MODE_RUN);

  // Software registers.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      clkDiv     <= CLKDIV_RESET;
      modStopReg <= MSTOP_RESET[NUM_MODULES-1:0];
      lpCtl      <= LPCTL_RESET;
      regRdata   <= 32'h0000_0000;
    end
    else
    begin
      if (wrClkDiv)
        clkDiv <= regWdata;
      if (wrMstop)
        modStopReg <= regWdata[NUM_MODULES-1:0];
      if (wrLpCtl)
        lpCtl <= regWdata[2:0];
      regRdata <= next_rdata;
    end
  end

  // Mode machine; reset always returns to run.
  // A reset in any low-power state therefore restarts from run.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      mode <= MODE_RUN;
    else
      mode <= next_mode;
  end

  // Divider counter and bus clock phase.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      divCnt   <= '0;
      busPhase <= 1'b0;
    end
    else
    begin
      divCnt   <= divCnt + DIV_CNT_W'(1);
      busPhase <= next_busPhase;
    end
  end

  // Registered outputs.
  // Every output leaves a flip-flop, so no decode glitch reaches a pin.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      clkEnable  <= '0;
      busClkPin  <= 1'b1;
      moduleStop <= '0;
      unitCtl    <= '0;
      wakeToIrq  <= 1'b0;
    end
    else
    begin
      clkEnable  <= next_clkEnable;
      busClkPin  <= next_busPin;
      moduleStop <= next_modStop;
      unitCtl    <= next_unit;
      wakeToIrq  <= next_wake;
    end
  end

endmodule : low_power_mode_controller

// ### lpm_pkg.sv
// Shared constants and types for the low-power mode controller.
package lpm_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [7:0] REG_CLKDIV = 8'h00;
  localparam logic [7:0] REG_MSTOP  = 8'h04;
  localparam logic [7:0] REG_LPCTL  = 8'h08;
  localparam logic [7:0] REG_STAT   = 8'h0C;

  // Divider field indices inside the clock divider register.
  localparam int NUM_CLK   = 7;
  localparam int CLK_CORE  = 0;
  localparam int CLK_PA    = 1;
  localparam int CLK_PB    = 2;
  localparam int CLK_PC    = 3;
  localparam int CLK_PD    = 4;
  localparam int CLK_BUS   = 5;
  localparam int CLK_FLASH = 6;
  localparam int SEL_W     = 4;
  localparam int BCLK_HIGH_BIT = 28;
  localparam logic [3:0] SEL_MAX = 4'h6;
  localparam int DIV_CNT_W = 6;

  localparam logic [31:0] CLKDIV_RESET = 32'h0000_0000;
  localparam logic [31:0] MSTOP_RESET  = 32'h0000_0000;

  localparam int LP_ALLSTOP_BIT = 0;
  localparam int LP_STANDBY_BIT = 1;
  localparam int LP_DEEP_BIT    = 2;
  localparam logic [2:0] LPCTL_RESET = 3'h0;

  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_ALLSTOP,
    MODE_SWSTBY,
    MODE_DEEPSTBY
  } lp_mode_t;

  typedef struct packed {
    logic cpuHalt;
    logic ramStop;
    logic flashStop;
    logic periphStop;
    logic watchdogStop;
    logic indepWdRun;
    logic shutoffRun;
    logic timerRun;
    logic usbRun;
    logic oscStop;
    logic deepPowerOff;
  } unit_ctl_t;

endpackage : lpm_pkg

// ### low_power_mode_controller_properties.sv
// Port assertions for the low-power mode controller.
`timescale 1ns/10ps
module lpm_properties
  import lpm_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic               regRd,
  input wire logic [DATA_W-1:0]  regRdata,
  input wire logic               waitInstr,
  input wire logic               irqPending,
  input wire logic [NUM_CLK-1:0] clkEnable,
  input wire unit_ctl_t          unitCtl,
  input wire logic               wakeToIrq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_read_idle: assert property (
    !$past(regRd) |-> regRdata == '0) else $error("read data not idle");
  a_wait_enter: assert property (
    rst_n && !unitCtl.cpuHalt && waitInstr |=> unitCtl.cpuHalt)
    else $error("wait did not halt core");
  a_no_enter: assert property (
    !unitCtl.cpuHalt && !waitInstr |=> !unitCtl.cpuHalt)
    else $error("core halted without wait");
  a_irq_wake: assert property (
    rst_n && unitCtl.cpuHalt && irqPending |=>
    wakeToIrq && !unitCtl.cpuHalt)
    else $error("interrupt did not wake");
  a_halt_holds: assert property (
    rst_n && unitCtl.cpuHalt && !irqPending |=>
    unitCtl.cpuHalt && !wakeToIrq)
    else $error("halt ended without interrupt");
  a_wake_once: assert property (
    wakeToIrq |=> !wakeToIrq) else $error("wake pulse too long");
  a_core_gate: assert property (
    unitCtl.cpuHalt |-> !clkEnable[CLK_CORE])
    else $error("core clock runs while halted");
  a_sleep_set: assert property (
    unitCtl.cpuHalt && !unitCtl.periphStop |-> unitCtl.watchdogStop &&
    unitCtl.shutoffRun && unitCtl.timerRun && unitCtl.usbRun &&
    !unitCtl.ramStop) else $error("sleep unit states wrong");
  a_allstop_mem: assert property (
    unitCtl.cpuHalt && unitCtl.periphStop |-> unitCtl.ramStop &&
    unitCtl.flashStop) else $error("memories run in stop");
endmodule : lpm_properties

bind low_power_mode_controller lpm_properties chk(.core_clk, .rst_n,
  .regRd, .regRdata, .waitInstr, .irqPending, .clkEnable, .unitCtl,
  .wakeToIrq);

// ### low_power_mode_controller_tb.sv
// Self-checking bench for the low-power mode controller.
`timescale 1ns/10ps
module low_power_mode_controller_tb import lpm_pkg::*;;
  logic core_clk = 0, rst_n = 0, regWr = 0, regRd = 0;
  logic waitInstr = 0, irqPending = 0, indepWdEnabled = 0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata, moduleStop;
  logic [6:0] clkEnable;
  logic busClkPin, wakeToIrq;
  unit_ctl_t unitCtl;
  int failures = 0, tests_run = 0;

  low_power_mode_controller DUT(.core_clk, .rst_n, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .waitInstr, .irqPending, .indepWdEnabled,
    .clkEnable, .busClkPin, .moduleStop, .unitCtl, .wakeToIrq);

  initial forever #10 core_clk = ~core_clk;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    cyc(1);
    regWr <= 1'b0;
    cyc(1);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    cyc(1);
    regRd <= 1'b0;
    cyc(1);
    chk(regRdata, exp);
  endtask : rdc

  task enter(input logic [31:0] code);
    wr(REG_LPCTL, code);
    waitInstr <= 1'b1;
    cyc(1);
    waitInstr <= 1'b0;
    cyc(1);
  endtask : enter

  task wake;
    irqPending <= 1'b1;
    cyc(1);
    irqPending <= 1'b0;
    cyc(1);
    chk({wakeToIrq, unitCtl.cpuHalt}, 32'h2);
    cyc(1);
    chk(wakeToIrq, 32'h0);
  endtask : wake

  task t_div;
    int cnt[7];
    int tog;
    logic prev;
    tog = 0;
    cnt = '{default: 0};
    wr(REG_CLKDIV, 32'h0654_3210);
    rdc(REG_CLKDIV, 32'h0654_3210);
    cyc(2);
    prev = busClkPin;
    repeat (64)
    begin
      cyc(1);
      for (int i = 0; i < 7; i++) cnt[i] += clkEnable[i];
      tog += (busClkPin !== prev);
      prev = busClkPin;
    end
    for (int i = 0; i < 7; i++) chk(cnt[i], 64 >> i);
    chk(tog, 32'h2);
    wr(REG_CLKDIV, 32'h1000_0000);
    cyc(2);
    repeat (8)
    begin
      cyc(1);
      chk(busClkPin, 32'h1);
    end
  endtask : t_div

  task t_modes;
    logic [31:0] code[3];
    code = '{32'h1, 32'h2, 32'h6};
    for (int i = 0; i < 3; i++)
    begin
      enter(code[i]);
      rdc(REG_STAT, 32'h22 + i);
      chk({unitCtl.ramStop, unitCtl.flashStop}, 32'h3);
      chk(moduleStop, 32'hFFFF_FFFF);
      chk(unitCtl.oscStop, i > 0);
      chk(unitCtl.deepPowerOff, i == 2);
      wake();
    end
  endtask : t_modes

  task summarize;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  initial
  begin
    cyc(5);
    rst_n <= 1'b1;
    cyc(1);
    chk({busClkPin, clkEnable, unitCtl}, 32'h40000);
    t_div();
    wr(REG_MSTOP, 32'h0000_00A5);
    wr(8'h40, 32'hFFFF_FFFF);
    rdc(8'h40, 32'h0);
    chk(moduleStop, 32'hA5);
    indepWdEnabled <= 1'b1;
    irqPending <= 1'b1;
    cyc(2);
    chk({wakeToIrq, unitCtl.cpuHalt}, 32'h0);
    irqPending <= 1'b0;
    enter(32'h0);
    chk(unitCtl, 32'h47C);
    chk(moduleStop, 32'hA5);
    rdc(REG_STAT, 32'h21);
    wake();
    t_modes();
    enter(32'h1);
    rst_n <= 1'b0;
    cyc(1);
    rst_n <= 1'b1;
    cyc(2);
    chk(unitCtl, 32'h3C);
    chk(moduleStop, 32'h0);
    rdc(REG_STAT, 32'h20);
    rdc(REG_LPCTL, 32'h0);
    summarize();
  end
endmodule : low_power_mode_controller_tb
